// ---- rtl/station_fault_mask_defs.svh ----
// Register offsets, field positions and timing counts of the station block
`ifndef STATION_FAULT_MASK_DEFS_SVH
`define STATION_FAULT_MASK_DEFS_SVH

`define STATION_COUNT 64

// Register byte offsets
`define ADR_CTRL 8'h00
`define ADR_STATUS 8'h04
`define ADR_RSV_STAGE_LO 8'h08
`define ADR_RSV_STAGE_HI 8'h0c
`define ADR_EINV_STAGE_LO 8'h10
`define ADR_EINV_STAGE_HI 8'h14
`define ADR_TEMP_EINV_LO 8'h18
`define ADR_TEMP_EINV_HI 8'h1c
`define ADR_FAULTY_LO 8'h20
`define ADR_FAULTY_HI 8'h24
`define ADR_RSV_LO 8'h28
`define ADR_RSV_HI 8'h2c
`define ADR_EINV_LO 8'h30
`define ADR_EINV_HI 8'h34

// Control fields
`define CTRL_SYNC 0
`define CTRL_RATE_LO 1
`define CTRL_RATE_HI 3
`define CTRL_REMOTE_NET 4
`define CTRL_ONLINE 5
`define CTRL_LOAD 6

// Status fields
`define STAT_ERR_LED 0
`define STAT_LINK_RUN 1
`define STAT_TIMEOUT 2
`define STAT_SYNC 3

// Timing
`define CLK_KHZ 125000
`define MS_CYCLES(ms) ((ms) * `CLK_KHZ)
`define US_CYCLES(us) ((us) * `CLK_KHZ / 1000)
`define BOUND_FAST_MS 50
`define BOUND_2M5_MS 100
`define BOUND_625K_MS 400
`define BOUND_156K_MS 800
`define ASYNC_PERIOD_US 4000
`define LINK_SCAN_US 1000

`endif

// ---- rtl/station_fault_mask_pkg.sv ----
// Types shared by the station supervision block
package station_fault_mask_pkg;

  typedef enum logic [2:0] {
    RATE_10M, RATE_5M, RATE_2M5, RATE_625K, RATE_156K
  } rate_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic online;
    logic remote_net;
    rate_t rate;
    logic sync;
  } ctrl_t;

  typedef logic [63:0] station_vec_t;

endpackage

// ---- rtl/scan_pacer.sv ----
// Link scan start pacing and sequence scan timeout watch
`timescale 1ns/1ns
`default_nettype none
module scan_pacer #(
  parameter logic [26:0] BOUND_FAST = 27'd1,
  parameter logic [26:0] BOUND_2M5 = 27'd1,
  parameter logic [26:0] BOUND_625K = 27'd1,
  parameter logic [26:0] BOUND_156K = 27'd1,
  parameter logic [26:0] ASYNC_PERIOD = 27'd1,
  parameter logic [26:0] SCAN_LEN = 27'd1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic online_i,
  input wire logic sync_i,
  input wire station_fault_mask_pkg::rate_t rate_i,
  input wire logic seq_start_i,
  output logic scan_start_o,
  output logic timeout_o,
  output logic busy_o
);
  import station_fault_mask_pkg::*;

  logic [26:0] since;
  logic [26:0] busy_cnt;
  logic [26:0] bound;
  logic next_start;

  always_comb begin
    unique case (rate_i)
      RATE_10M, RATE_5M: bound = BOUND_FAST;
      RATE_2M5: bound = BOUND_2M5;
      RATE_625K: bound = BOUND_625K;
      default: bound = BOUND_156K;
    endcase
  end

  // Sync: follow host scan; async: own period
  always_comb begin
    if (!online_i) begin
      next_start = 1'b0;
    end else if (sync_i) begin
      next_start = seq_start_i;
    end else begin
      next_start = (since >= ASYNC_PERIOD - 27'd1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || next_start || (sync_i && seq_start_i)) begin
      since <= '0;
    end else if (since != '1) begin
      since <= since + 27'd1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scan_start_o <= 1'b0;
      timeout_o <= 1'b0;
    end else begin
      scan_start_o <= next_start;
      timeout_o <= online_i && sync_i && !seq_start_i &&
                   (since == bound - 27'd1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_cnt <= '0;
    end else if (next_start) begin
      busy_cnt <= SCAN_LEN;
    end else if (busy_cnt != '0) begin
      busy_cnt <= busy_cnt - 27'd1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= next_start || (busy_cnt > 27'd1);
    end
  end

endmodule
`default_nettype wire

// ---- rtl/station_fault_mask_scan_sync.sv ----
// Station fault masking, reserved handling and link scan synchronisation
//
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "station_fault_mask_defs.svh"
module station_fault_mask_scan_sync #(
  parameter logic FUNC_REV_A = 1'b0,
  parameter logic [26:0] BOUND_FAST =
    27'(`MS_CYCLES(`BOUND_FAST_MS)),
  parameter logic [26:0] BOUND_2M5 =
    27'(`MS_CYCLES(`BOUND_2M5_MS)),
  parameter logic [26:0] BOUND_625K =
    27'(`MS_CYCLES(`BOUND_625K_MS)),
  parameter logic [26:0] BOUND_156K =
    27'(`MS_CYCLES(`BOUND_156K_MS)),
  parameter logic [26:0] ASYNC_PERIOD =
    27'(`US_CYCLES(`ASYNC_PERIOD_US)),
  parameter logic [26:0] SCAN_LEN =
    27'(`US_CYCLES(`LINK_SCAN_US))
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire station_fault_mask_pkg::wb_req_t wb_i,
  output station_fault_mask_pkg::wb_rsp_t wb_o,
  input wire logic seq_scan_start_i,
  input wire station_fault_mask_pkg::station_vec_t station_fault_i,
  input wire station_fault_mask_pkg::station_vec_t link_rx_i,
  input wire station_fault_mask_pkg::station_vec_t host_ry_i,
  output station_fault_mask_pkg::station_vec_t link_enable_o,
  output station_fault_mask_pkg::station_vec_t rx_refresh_o,
  output station_fault_mask_pkg::station_vec_t ry_drive_o,
  output station_fault_mask_pkg::station_vec_t faulty_o,
  output logic link_scan_start_o,
  output logic err_led_o,
  output logic link_run_led_o,
  output logic scan_timeout_o
);
  import station_fault_mask_pkg::*;

  // ****************************************************
  // Register state
  // ****************************************************
  ctrl_t ctrl;
  station_vec_t rsv_stage;
  station_vec_t einv_stage;
  station_vec_t rsv;
  station_vec_t einv;
  station_vec_t temp_einv;
  station_vec_t next_faulty;
  station_vec_t eff_einv;
  station_vec_t temp_down;
  logic timeout_flag;
  logic sync_eff;
  logic scan_start;
  logic timeout_pulse;
  logic scan_busy;
  logic req;
  logic wr;
  logic param_load;
  logic [31:0] next_rdata;

  // ****************************************************
  // Bus decode
  // ****************************************************
  assign req = wb_i.cyc && wb_i.stb;
  // Write commits at the edge where ack is seen high
  assign wr = req && wb_i.we && wb_o.ack;

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] val,
    input logic [3:0] sel
  );
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = val[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic hit(input logic [7:0] a);
    return wr && (wb_i.adr == a);
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_o.ack <= 1'b0;
    end else begin
      wb_o.ack <= req && !wb_o.ack;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_o.dat <= 32'h0;
    end else if (req && !wb_o.ack) begin
      wb_o.dat <= next_rdata;
    end
  end

  // ****************************************************
  // Control register
  // ****************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= '0;
    end else if (hit(`ADR_CTRL) && wb_i.sel[0]) begin
      ctrl.sync <= wb_i.dat[`CTRL_SYNC];
      ctrl.rate <= rate_t'(wb_i.dat[`CTRL_RATE_HI:`CTRL_RATE_LO]);
      ctrl.remote_net <= wb_i.dat[`CTRL_REMOTE_NET];
      ctrl.online <= wb_i.dat[`CTRL_ONLINE];
    end
  end

  // Load accepted only while offline
  assign param_load = hit(`ADR_CTRL) && wb_i.sel[0] &&
                      wb_i.dat[`CTRL_LOAD] && !ctrl.online;

  // Earliest revision needs remote net mode for sync
  assign sync_eff = ctrl.sync &&
                    (!FUNC_REV_A || ctrl.remote_net);

  // ****************************************************
  // Staged parameter vectors
  // ****************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsv_stage <= '0;
    end else if (hit(`ADR_RSV_STAGE_LO)) begin
      rsv_stage[31:0] <= merge(rsv_stage[31:0], wb_i.dat, wb_i.sel);
    end else if (hit(`ADR_RSV_STAGE_HI)) begin
      rsv_stage[63:32] <= merge(rsv_stage[63:32], wb_i.dat, wb_i.sel);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      einv_stage <= '0;
    end else if (hit(`ADR_EINV_STAGE_LO)) begin
      einv_stage[31:0] <= merge(einv_stage[31:0], wb_i.dat, wb_i.sel);
    end else if (hit(`ADR_EINV_STAGE_HI)) begin
      einv_stage[63:32] <= merge(einv_stage[63:32], wb_i.dat, wb_i.sel);
    end
  end

  // ****************************************************
  // Active mark vectors
  // ****************************************************
  // Fixed while online; only a load replaces them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsv <= '0;
      einv <= '0;
    end else if (param_load) begin
      rsv <= rsv_stage;
      einv <= einv_stage;
    end
  end

  // Temporary marks are writable at any time
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      temp_einv <= '0;
    end else if (hit(`ADR_TEMP_EINV_LO)) begin
      temp_einv[31:0] <= merge(temp_einv[31:0], wb_i.dat,
                               wb_i.sel);
    end else if (hit(`ADR_TEMP_EINV_HI)) begin
      temp_einv[63:32] <= merge(temp_einv[63:32], wb_i.dat,
                                wb_i.sel);
    end
  end

  // ****************************************************
  // Scan pacing
  // ****************************************************
  scan_pacer #(
    .BOUND_FAST(BOUND_FAST),
    .BOUND_2M5(BOUND_2M5),
    .BOUND_625K(BOUND_625K),
    .BOUND_156K(BOUND_156K),
    .ASYNC_PERIOD(ASYNC_PERIOD),
    .SCAN_LEN(SCAN_LEN)
  ) pacer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .online_i(ctrl.online),
    .sync_i(sync_eff),
    .rate_i(ctrl.rate),
    .seq_start_i(seq_scan_start_i),
    .scan_start_o(scan_start),
    .timeout_o(timeout_pulse),
    .busy_o(scan_busy)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_scan_start_o <= 1'b0;
    end else begin
      link_scan_start_o <= scan_start;
    end
  end

  // Sticky timeout, write one to clear, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timeout_flag <= 1'b0;
    end else if (timeout_pulse) begin
      timeout_flag <= 1'b1;
    end else if (hit(`ADR_STATUS) && wb_i.sel[0] &&
                 wb_i.dat[`STAT_TIMEOUT]) begin
      timeout_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scan_timeout_o <= 1'b0;
    end else begin
      scan_timeout_o <= timeout_flag || timeout_pulse;
    end
  end

  // Steady in async mode, follows scan in sync mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_run_led_o <= 1'b0;
    end else begin
      link_run_led_o <= ctrl.online &&
                        (!sync_eff || scan_busy);
    end
  end

  // ****************************************************
  // Per-station masking and data handling
  // ****************************************************
  for (genvar i = 0; i < `STATION_COUNT; i++) begin : g_station
    // Reserved overrides error-invalid
    assign eff_einv[i] = einv[i] && !rsv[i];
    assign temp_down[i] = temp_einv[i] && station_fault_i[i];
    assign next_faulty[i] = station_fault_i[i] && !rsv[i] &&
                            !eff_einv[i] && !temp_einv[i];

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        faulty_o[i] <= 1'b0;
        link_enable_o[i] <= 1'b0;
      end else begin
        faulty_o[i] <= next_faulty[i];
        link_enable_o[i] <= ctrl.online && !rsv[i];
      end
    end

    // Input refresh each scan, held while temp station is down
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        rx_refresh_o[i] <= 1'b0;
      end else if (rsv[i]) begin
        rx_refresh_o[i] <= 1'b0;
      end else if (scan_start && !temp_down[i]) begin
        rx_refresh_o[i] <= link_rx_i[i];
      end
    end

    // Output refresh each scan, forced off while temp station is down
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ry_drive_o[i] <= 1'b0;
      end else if (rsv[i] || temp_down[i]) begin
        ry_drive_o[i] <= 1'b0;
      end else if (scan_start) begin
        ry_drive_o[i] <= host_ry_i[i];
      end
    end
  end

  // ****************************************************
  // Error indicator
  // ****************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_led_o <= 1'b0;
    end else begin
      err_led_o <= (|next_faulty) ||
                   ((&eff_einv) && (&station_fault_i));
    end
  end

  // ****************************************************
  // Read data
  // ****************************************************
  always_comb begin
    next_rdata = 32'h0;
    unique case (wb_i.adr)
      `ADR_CTRL: begin
        next_rdata[`CTRL_SYNC] = ctrl.sync;
        next_rdata[`CTRL_RATE_HI:`CTRL_RATE_LO] = ctrl.rate;
        next_rdata[`CTRL_REMOTE_NET] = ctrl.remote_net;
        next_rdata[`CTRL_ONLINE] = ctrl.online;
      end
      `ADR_STATUS: begin
        next_rdata[`STAT_ERR_LED] = err_led_o;
        next_rdata[`STAT_LINK_RUN] = link_run_led_o;
        next_rdata[`STAT_TIMEOUT] = timeout_flag;
        next_rdata[`STAT_SYNC] = sync_eff;
      end
      `ADR_RSV_STAGE_LO: next_rdata = rsv_stage[31:0];
      `ADR_RSV_STAGE_HI: next_rdata = rsv_stage[63:32];
      `ADR_EINV_STAGE_LO: next_rdata = einv_stage[31:0];
      `ADR_EINV_STAGE_HI: next_rdata = einv_stage[63:32];
      `ADR_TEMP_EINV_LO: next_rdata = temp_einv[31:0];
      `ADR_TEMP_EINV_HI: next_rdata = temp_einv[63:32];
      `ADR_FAULTY_LO: next_rdata = faulty_o[31:0];
      `ADR_FAULTY_HI: next_rdata = faulty_o[63:32];
      `ADR_RSV_LO: next_rdata = rsv[31:0];
      `ADR_RSV_HI: next_rdata = rsv[63:32];
      `ADR_EINV_LO: next_rdata = einv[31:0];
      `ADR_EINV_HI: next_rdata = einv[63:32];
      default: next_rdata = 32'h0;
    endcase
  end

endmodule
`default_nettype wire

// ---- verif/station_fault_mask_scan_sync_chk.sv ----
// Port-level assertions for the station supervision block
`timescale 1ns/1ns
`default_nettype none
`include "station_fault_mask_defs.svh"
module station_fault_mask_scan_sync_chk #(
  parameter logic [26:0] ASYNC_PERIOD = 27'd1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire station_fault_mask_pkg::wb_req_t wb_i,
  input wire station_fault_mask_pkg::wb_rsp_t wb_o,
  input wire logic seq_scan_start_i,
  input wire station_fault_mask_pkg::station_vec_t station_fault_i,
  input wire station_fault_mask_pkg::station_vec_t ry_drive_o,
  input wire station_fault_mask_pkg::station_vec_t faulty_o,
  input wire logic link_scan_start_o,
  input wire logic err_led_o,
  input wire logic scan_timeout_o
);
  import station_fault_mask_pkg::*;
  // ****
  // Bus snoop and scan gap helpers
  // ****
  logic sync_on;
  logic online;
  logic steady;
  logic wr_ack;
  logic sync_run;
  logic [31:0] temp_lo;
  logic [31:0] hit;
  logic [26:0] gap;
  assign wr_ack = wb_i.cyc && wb_i.stb && wb_i.we && wb_o.ack;
  assign sync_run = online && sync_on;
  assign hit = station_fault_i[31:0] & temp_lo;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_on <= 1'b0;
      online <= 1'b0;
      temp_lo <= '0;
    end else if (wr_ack && wb_i.adr == `ADR_CTRL) begin
      sync_on <= wb_i.dat[`CTRL_SYNC];
      online <= wb_i.dat[`CTRL_ONLINE];
    end else if (wr_ack && wb_i.adr == `ADR_TEMP_EINV_LO) begin
      temp_lo <= wb_i.dat;
    end
  end
  // Gap is only trusted between two starts of one async stretch
  always_ff @(posedge clk_i) begin
    if (rst_i || wr_ack) begin
      gap <= '0;
      steady <= 1'b0;
    end else if (link_scan_start_o) begin
      gap <= '0;
      steady <= online && !sync_on;
    end else begin
      gap <= gap + 27'd1;
    end
  end
  // ****
  // Properties
  // ****
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_start_2;
    ##2 link_scan_start_o;
  endsequence
  property p_sync_start;
    sync_run && seq_scan_start_i |-> s_start_2;
  endproperty
  a_sync_start: assert property (p_sync_start)
    else $error("link scan missed host scan start");
  property p_scan_pulse;
    link_scan_start_o |=> !link_scan_start_o;
  endproperty
  a_scan_pulse: assert property (p_scan_pulse)
    else $error("scan start pulse too long");
  property p_sync_only;
    link_scan_start_o && sync_run && $past(sync_run, 3)
      |-> $past(seq_scan_start_i, 2);
  endproperty
  a_sync_only: assert property (p_sync_only)
    else $error("sync scan without host scan start");
  property p_async;
    link_scan_start_o && steady |-> gap == ASYNC_PERIOD - 27'd1;
  endproperty
  a_async: assert property (p_async)
    else $error("async scan period wrong");
  property p_timeout;
    $rose(scan_timeout_o) |-> sync_run;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("timeout outside sync mode");
  property p_err_led;
    |faulty_o && $stable(faulty_o) |-> err_led_o;
  endproperty
  a_err_led: assert property (p_err_led)
    else $error("error led off with faulty stations");
  property p_temp_mask;
    hit != 32'h0 && $stable(hit) |-> (faulty_o[31:0] & hit) == 32'h0;
  endproperty
  a_temp_mask: assert property (p_temp_mask)
    else $error("temporary masked station reported");
  property p_temp_off;
    hit != 32'h0 && $stable(hit) && hit == $past(hit, 2)
      |-> (ry_drive_o[31:0] & hit) == 32'h0;
  endproperty
  a_temp_off: assert property (p_temp_off)
    else $error("faulty temporary station output on");
endmodule
bind station_fault_mask_scan_sync station_fault_mask_scan_sync_chk #(
  .ASYNC_PERIOD(ASYNC_PERIOD)
) i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o),
  .seq_scan_start_i(seq_scan_start_i),
  .station_fault_i(station_fault_i), .ry_drive_o(ry_drive_o),
  .faulty_o(faulty_o), .link_scan_start_o(link_scan_start_o),
  .err_led_o(err_led_o), .scan_timeout_o(scan_timeout_o));
`default_nettype wire

// ---- verif/station_net.sv ----
// Behavioural model of the field stations
`timescale 1ns/1ns
`default_nettype none
module station_net (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [63:0] off_i,
  input wire logic [63:0] data_i,
  output logic [63:0] fault_o,
  output logic [63:0] rx_o
);
  // ****
  // Older local station: short own scan, flag-gated transfers
  // ****
  localparam logic [2:0] LOCAL_SCAN_BOUND = 3'd5;
  logic [2:0] local_scan;
  logic local_handshake_flag;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      local_scan <= '0;
      local_handshake_flag <= 1'b0;
    end else begin
      // Local scan wraps one cycle short of local_scan_bound
      if (local_scan == LOCAL_SCAN_BOUND - 3'd2) begin
        local_scan <= '0;
      end else begin
        local_scan <= local_scan + 3'd1;
      end
      local_handshake_flag <= (local_scan == LOCAL_SCAN_BOUND - 3'd2);
    end
  end
  // ****
  // Powered-off stations go silent, line shows junk
  // ****
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_o <= '0;
      rx_o <= '0;
    end else begin
      fault_o <= off_i;
      if (local_handshake_flag) begin
        rx_o <= (data_i & ~off_i) | (~rx_o & off_i);
      end else begin
        rx_o <= (rx_o & ~off_i) | (~rx_o & off_i);
      end
    end
  end
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the station supervision block
`timescale 1ns/1ns
`default_nettype none
`include "station_fault_mask_defs.svh"
module tb_top;
  import station_fault_mask_pkg::*;
  typedef struct packed {
    logic [63:0] off;
    logic [31:0] temp;
    logic [63:0] flt;
    logic led;
  } row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic seq = 1'b0;
  wb_req_t req = '0;
  wb_rsp_t rsp;
  station_vec_t off = '0;
  station_vec_t data = '0;
  station_vec_t ry = '0;
  station_vec_t flt, rx, en, rxr, ryd, fty;
  logic lss, led, run, tmo;
  logic [63:0] rd;
  int mismatches = 0;
  int checks_done = 0;
  int cnt;
  localparam int T_FAST = 200;
  localparam int T_2M5 = 300;
  localparam int T_625K = 400;
  localparam int T_156K = 500;
  localparam int T_PERIOD = 50;
  localparam int T_SCAN = 10;
  int bound[5] = '{T_FAST, T_FAST, T_2M5, T_625K, T_156K};
  row_t rows[4] = '{
    '{64'h7, 32'h0, 64'h4, 1'b1},
    '{64'h7, 32'h4, 64'h0, 1'b0},
    '{64'h3, 32'h0, 64'h0, 1'b0},
    '{~64'h0, 32'h0, 64'hffff_ffff_ffff_fffc, 1'b1}};
  always #4 clk_i = ~clk_i;
  station_net i_net (.clk_i(clk_i), .rst_i(rst_i), .off_i(off),
    .data_i(data), .fault_o(flt), .rx_o(rx));
  station_fault_mask_scan_sync #(
    .BOUND_FAST(27'(T_FAST)), .BOUND_2M5(27'(T_2M5)),
    .BOUND_625K(27'(T_625K)), .BOUND_156K(27'(T_156K)),
    .ASYNC_PERIOD(27'(T_PERIOD)), .SCAN_LEN(27'(T_SCAN))
  ) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_i(req), .wb_o(rsp),
    .seq_scan_start_i(seq), .station_fault_i(flt), .link_rx_i(rx),
    .host_ry_i(ry), .link_enable_o(en), .rx_refresh_o(rxr),
    .ry_drive_o(ryd), .faulty_o(fty), .link_scan_start_o(lss),
    .err_led_o(led), .link_run_led_o(run), .scan_timeout_o(tmo));
  // ****
  // Tasks
  // ****
  task automatic stop_test;
    if (mismatches == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bail(input logic ok);
    if (ok !== 1'b1) begin
      mismatches++;
      stop_test();
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, we, a, 4'hf, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.ack !== 1'b1 && n < 20);
    rd = {32'h0, rsp.dat};
    req <= '0;
    bail(rsp.ack);
  endtask
  task automatic pulse;
    @(posedge clk_i);
    seq <= 1'b1;
    @(posedge clk_i);
    seq <= 1'b0;
  endtask
  task automatic starts(input int n);
    cnt = 0;
    repeat (n) begin
      @(posedge clk_i);
      if (lss === 1'b1) cnt++;
    end
  endtask
  task automatic to_scan;
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (lss !== 1'b1 && n < 100);
    bail(lss);
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(fty | en, 64'h0);
    chk({60'h0, lss, led, run, tmo}, 64'h0);
    wb(1, `ADR_RSV_STAGE_LO, 32'h1);
    wb(1, `ADR_EINV_STAGE_LO, 32'h3);
    wb(1, `ADR_CTRL, 32'h40);
    wb(0, `ADR_RSV_LO, 32'h0);
    chk(rd, 64'h1);
    wb(0, `ADR_EINV_LO, 32'h0);
    chk(rd, 64'h3);
    wb(1, `ADR_CTRL, 32'h20);
    wb(1, `ADR_EINV_STAGE_LO, 32'h0);
    wb(1, `ADR_CTRL, 32'h60);
    wb(0, `ADR_EINV_LO, 32'h0);
    chk(rd, 64'h3);
    chk(en, ~64'h1);
    foreach (rows[i]) begin
      off <= rows[i].off;
      wb(1, `ADR_TEMP_EINV_LO, rows[i].temp);
      repeat (4) @(posedge clk_i);
      chk(fty, rows[i].flt);
      chk({63'h0, led}, {63'h0, rows[i].led});
    end
    starts(4 * T_PERIOD);
    chk(64'(cnt), 64'h4);
    chk({63'h0, run}, 64'h1);
    off <= '0;
    data <= ~64'h0;
    ry <= ~64'h0;
    wb(1, `ADR_TEMP_EINV_LO, 32'h4);
    repeat (120) @(posedge clk_i);
    chk(rxr, ~64'h1);
    chk(ryd, ~64'h1);
    to_scan();
    off <= 64'h4;
    data <= '0;
    repeat (120) @(posedge clk_i);
    chk(rxr, 64'h4);
    chk(ryd, ~64'h5);
    wb(1, `ADR_CTRL, 32'h21);
    for (int i = 1; i < 3; i++) begin
      pulse();
      repeat (2) @(posedge clk_i);
      chk({63'h0, lss}, 64'h1);
      starts(i * 40);
      chk(64'(cnt), 64'h0);
      chk({63'h0, run}, 64'h0);
    end
    for (int i = 0; i < 5; i++) begin
      wb(1, `ADR_CTRL, 32'h21 | 32'(i << 1));
      pulse();
      wb(1, `ADR_STATUS, 32'h4);
      repeat (bound[i] - 12) @(posedge clk_i);
      chk({63'h0, tmo}, 64'h0);
      repeat (16) @(posedge clk_i);
      chk({63'h0, tmo}, 64'h1);
    end
    wb(1, `ADR_CTRL, 32'h0);
    wb(1, `ADR_RSV_STAGE_LO, 32'h0);
    wb(1, `ADR_EINV_STAGE_LO, ~32'h0);
    wb(1, `ADR_EINV_STAGE_HI, ~32'h0);
    wb(1, `ADR_CTRL, 32'h40);
    off <= ~64'h0;
    repeat (6) @(posedge clk_i);
    chk(fty, 64'h0);
    chk({63'h0, led}, 64'h1);
    stop_test();
  end
endmodule
`default_nettype wire
